// File: hw/ctg_cpu_port.sv
/*
 * Management-port logic of a multi-port switch: traps control and IGMP
 * frames, inserts a 4-byte tag toward the processor, removes an 8-byte
 * command tag from processor frames, and appends a fresh FCS on both paths.
 * Assumes input streams carry no FCS (the receive MAC drops it), the CPU MAC
 * and the fabric accept one byte per cycle, and the AHB is idle while
 * ce_in is low.
 */
// Overview of operation
// RQ1: trap frames to the bridge group address 01-80-C2-00-00-00.
// RQ2: trap frames to the slow-protocol address ending 02.
// RQ3: trap frames to the port access entity address ending 03.
// RQ4: trap frames to reserved addresses ending 04 through 0f inclusive.
// RQ5: trap frames to the GMRP address ending 20.
// RQ6: trap frames to the GVRP address ending 21.
// RQ7: trap frames to the reserved address ending 22.
// RQ8: trap IPv4 multicast frames carrying IP protocol 2.
// RQ9: when enabled, insert a 4-byte tag into frames sent to the processor.
// RQ10: when enabled, remove the 8-byte command tag from processor frames.
// RQ11: both tag features follow control bits; processor adds tag only then.
// RQ12: a label mismatch leaves the frame untouched and handled normally.
// RQ13: egress-map valid set forwards by the map, else normally; default 0.
// RQ14: processor sets bit 26 for multi-port and bit x per target port.
// RQ15: tag field carries the VLAN tag value when the port is tagged.
// RQ16: inserted tag carries the 5-bit ingress port number.
// RQ17: queue valid set overrides queueing by queue select, else normal.
// RQ18: queue select 1 means high queue, 0 means low queue.
// RQ19: learn valid set follows learn select, else the learn-disable bit.
// RQ20: learn select 1 learns the source address, 0 suppresses it.
// RQ21: frames leave with a recomputed FCS after tag changes.
`timescale 1ns/1ps
module ctg_cpu_port
	import ctg_pkg::*;
(
	input  wire logic               mclk_in,
	input  wire logic               rst_b_in,
	input  wire logic               ce_in,
	input  wire logic               hsel_in,
	input  wire logic [31:0]        haddr_in,
	input  wire logic [1:0]         htrans_in,
	input  wire logic               hwrite_in,
	input  wire logic [2:0]         hsize_in,
	input  wire logic [31:0]        hwdata_in,
	input  wire logic               hready_in,
	output logic [31:0]             hrdata_out,
	output logic                    hreadyout_out,
	output logic                    hresp_out,
	input  wire logic               rx_valid_in,
	input  wire ctg_pkg::ctg_byte_t rx_in,
	output logic                    trap_valid_out,
	output logic                    trap_cpu_out,
	input  wire logic               tx_valid_in,
	input  wire ctg_pkg::ctg_byte_t tx_in,
	input  wire logic [4:0]         tx_src_in,
	output logic                    tx_ready_out,
	output logic                    cpu_valid_out,
	output ctg_pkg::ctg_byte_t      cpu_out,
	input  wire logic               cpu_valid_in,
	input  wire ctg_pkg::ctg_byte_t cpu_in,
	output logic                    cpu_ready_out,
	output logic                    fab_valid_out,
	output ctg_pkg::ctg_byte_t      fab_out,
	output logic                    cmd_valid_out,
	output ctg_pkg::ctg_cmd_t       cmd_out
);
	import ctg_pkg::*;

	default clocking ctg_cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	////////////////////////////////////////////////////////////////////////
	// register file on the AHB-Lite slave, zero wait states
	logic [3:0]  ctrl;
	logic [7:0]  label;
	logic [15:0] vtag;
	logic [15:0] trap_cnt;
	logic [15:0] strip_cnt;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic [31:0] rd_word;
	logic        ahb_req;

	assign ahb_req = hsel_in & hready_in & htrans_in[1];
	assign rd_word =
		(haddr_in[7:0] == CTG_ADDR_CTRL)  ? {28'h0000000, ctrl} :
		(haddr_in[7:0] == CTG_ADDR_LABEL) ? {24'h000000, label} :
		(haddr_in[7:0] == CTG_ADDR_VTAG)  ? {16'h0000, vtag} :
		(haddr_in[7:0] == CTG_ADDR_STAT)  ? {strip_cnt, trap_cnt} :
		32'h00000000;

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			wr_pend       <= 1'b0;
			wr_addr       <= 8'h00;
			hrdata_out    <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			ctrl          <= CTG_CTRL_RST;
			label         <= CTG_LABEL_RST;
			vtag          <= CTG_VTAG_RST;
		end else if (ce_in) begin
			wr_pend <= ahb_req & hwrite_in;
			if (ahb_req) begin
				wr_addr <= haddr_in[7:0];
			end
			if (ahb_req & ~hwrite_in) begin
				hrdata_out <= rd_word;
			end
			// see RQ11
			if (wr_pend && wr_addr == CTG_ADDR_CTRL) begin
				ctrl <= hwdata_in[3:0];
			end
			if (wr_pend && wr_addr == CTG_ADDR_LABEL) begin
				label <= hwdata_in[7:0];
			end
			if (wr_pend && wr_addr == CTG_ADDR_VTAG) begin
				vtag <= hwdata_in[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trap classifier on the receive stream; decision two cycles after last
	logic [4:0]  r_idx;
	logic [47:0] r_da;
	logic [15:0] r_etype;
	logic [7:0]  r_proto;
	logic        r_done;
	logic        rx_take;
	logic        rsv_hit;
	logic        igmp_hit;

	assign rx_take  = ce_in & rx_valid_in;
	// see RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
	// suffix 01 lies inside the low range but is not in the trap set
	assign rsv_hit  = (r_da[47:8] == CTG_RSV_PFX) &&
		((r_da[7:0] <= CTG_RSV_LO_MAX && r_da[7:0] != 8'h01) ||
		 (r_da[7:0] >= CTG_GARP_MIN && r_da[7:0] <= CTG_GARP_MAX));
	// see RQ8
	assign igmp_hit = (r_da[47:24] == CTG_IPMC_PFX) &&
		(r_etype == CTG_ETYPE_IP) && (r_proto == CTG_PROTO_IGMP);

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			r_idx          <= 5'h00;
			r_da           <= 48'h000000000000;
			r_etype        <= 16'h0000;
			r_proto        <= 8'h00;
			r_done         <= 1'b0;
			trap_valid_out <= 1'b0;
			trap_cpu_out   <= 1'b0;
			trap_cnt       <= CTG_CNT_RST;
		end else if (ce_in) begin
			r_done         <= rx_take & rx_in.last;
			trap_valid_out <= r_done;
			if (r_done) begin
				trap_cpu_out <= rsv_hit | igmp_hit;
				trap_cnt     <= trap_cnt + {15'h0000, rsv_hit | igmp_hit};
			end
			if (rx_take) begin
				r_idx <= rx_in.last ? 5'h00 :
					(r_idx == 5'h1f) ? r_idx : r_idx + 5'h01;
				// first byte wipes what a short earlier frame left behind
				if (r_idx == 5'h00) begin
					r_da    <= {40'h0000000000, rx_in.data};
					r_etype <= 16'h0000;
					r_proto <= 8'h00;
				end else if (r_idx < CTG_DA_BYTES) begin
					r_da <= {r_da[39:0], rx_in.data};
				end
				if (r_idx == CTG_ETH_HI_IDX) begin
					r_etype[15:8] <= rx_in.data;
				end
				if (r_idx == CTG_ETH_LO_IDX) begin
					r_etype[7:0] <= rx_in.data;
				end
				if (r_idx == CTG_PROTO_IDX) begin
					r_proto <= rx_in.data;
				end
			end
		end
	end

	AST_TRAP_RSV: assert property (r_done && rsv_hit && ce_in |=> // see RQ1 RQ4 RQ7
		trap_valid_out && trap_cpu_out)
		else $error("reserved group frame not trapped");
	AST_TRAP_IGMP: assert property ( // see RQ8
		r_done && igmp_hit && ce_in |=> trap_valid_out && trap_cpu_out)
		else $error("igmp frame not trapped");
	AST_TRAP_NONE: assert property ( // see RQ2 RQ3 RQ5 RQ6
		r_done && !rsv_hit && !igmp_hit && ce_in |=>
		trap_valid_out && !trap_cpu_out)
		else $error("ordinary frame trapped");
	CV_TRAP_IGMP: cover property (r_done && igmp_hit);

	////////////////////////////////////////////////////////////////////////
	// toward the processor: 4-byte tag after the source address
	ctg_ins_st_t a_state;
	logic [3:0]  a_cnt;
	logic [1:0]  a_idx;
	logic [4:0]  a_src;
	logic [31:0] a_crc;
	logic        a_take;
	logic        a_emit;
	logic        a_crc_upd;
	logic [31:0] a_tag_word;
	logic [7:0]  a_byte;

	assign a_take     = ce_in & tx_valid_in & tx_ready_out;
	// see RQ15 RQ16
	assign a_tag_word = {(ctrl[CTG_CTRL_TAGD] ? vtag : 16'h0000),
		label, 3'b000, a_src};
	assign a_crc_upd  = (a_state == A_DATA && a_take) || a_state == A_TAG;
	assign a_emit     = a_crc_upd || a_state == A_FCS;
	assign a_byte     = (a_state == A_TAG) ? a_tag_word[{~a_idx, 3'b000} +: 8] :
		(a_state == A_FCS) ? ~a_crc[{a_idx, 3'b000} +: 8] : tx_in.data;

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			a_state       <= A_DATA;
			a_cnt         <= 4'h0;
			a_idx         <= 2'h0;
			a_src         <= 5'h00;
			a_crc         <= CTG_CRC_INIT;
			tx_ready_out  <= 1'b1;
			cpu_valid_out <= 1'b0;
			cpu_out       <= '0;
		end else if (ce_in) begin
			cpu_valid_out <= a_emit;
			cpu_out.data  <= a_byte;
			cpu_out.last  <= (a_state == A_FCS) && (a_idx == CTG_INS_LAST);
			if (a_crc_upd) begin
				a_crc <= ctg_crc_byte(a_crc, a_byte); // see RQ21
			end
			unique case (a_state)
				A_DATA: if (a_take) begin
					a_idx <= 2'h0;
					if (a_cnt <= CTG_SA_END) begin
						a_cnt <= a_cnt + 4'h1;
					end
					if (a_cnt == 4'h0) begin
						a_src <= tx_src_in;
					end
					if (tx_in.last) begin
						a_state      <= A_FCS;
						tx_ready_out <= 1'b0;
					end else if (ctrl[CTG_CTRL_INS] && a_cnt == CTG_SA_END) begin
						a_state      <= A_TAG; // see RQ9 RQ11
						tx_ready_out <= 1'b0;
					end
				end
				A_TAG: begin
					a_idx <= a_idx + 2'h1;
					if (a_idx == CTG_INS_LAST) begin
						a_state      <= A_DATA;
						tx_ready_out <= 1'b1;
					end
				end
				A_FCS: begin
					a_idx <= a_idx + 2'h1;
					if (a_idx == CTG_INS_LAST) begin
						a_state      <= A_DATA;
						tx_ready_out <= 1'b1;
						a_cnt        <= 4'h0;
						a_crc        <= CTG_CRC_INIT;
					end
				end
			endcase
		end
	end

	AST_INS_SRC: assert property ( // see RQ16
		a_state == A_TAG && a_idx == CTG_INS_LAST && ce_in |=>
		cpu_valid_out && cpu_out.data == {3'b000, $past(a_src)})
		else $error("inserted tag lacks the source port");
	AST_INS_ENTRY: assert property ( // see RQ9
		a_take && !tx_in.last && ctrl[CTG_CTRL_INS] && a_cnt == CTG_SA_END
		|=> a_state == A_TAG && !tx_ready_out && a_idx == 2'h0)
		else $error("tag insertion not started after the source address");
	AST_FCS_END: assert property ( // see RQ21
		a_state == A_FCS && a_idx == CTG_INS_LAST && ce_in |=>
		cpu_out.last && cpu_out.data == ~$past(a_crc[31:24]) ##1
		a_crc == CTG_CRC_INIT)
		else $error("fcs tail wrong toward the processor");
	CV_INS: cover property (a_state == A_TAG ##1 a_state == A_TAG);

	////////////////////////////////////////////////////////////////////////
	// from the processor: 8-byte command tag, replayed on a label mismatch
	ctg_rem_st_t b_state;
	logic [3:0]  b_cnt;
	logic [2:0]  b_idx;
	logic [2:0]  b_end;
	logic        b_eof;
	logic [7:0]  b_buf [8];
	logic [31:0] b_crc;
	ctg_cmd_t    b_pend;
	logic        b_lv;
	logic        b_take;
	logic        b_cmd_done;
	logic        b_match;
	logic        b_crc_upd;
	logic        b_emit;
	logic        b_fcs_end;
	logic [7:0]  b_byte;
	ctg_cmd_t    b_parsed;

	assign b_take     = ce_in & cpu_valid_in & cpu_ready_out;
	assign b_cmd_done = b_state == B_HOLD && b_take &&
		b_idx == CTG_CMD_LAST && !cpu_in.last;
	assign b_match    = b_cmd_done && b_buf[0] == label; // see RQ12
	assign b_crc_upd  = (b_state == B_DATA && b_take) || b_state == B_REPLAY;
	assign b_emit     = b_crc_upd || b_state == B_FCS;
	assign b_fcs_end  = b_state == B_FCS && b_idx == CTG_FCS_LAST;
	assign b_byte     = (b_state == B_REPLAY) ? b_buf[b_idx] :
		(b_state == B_FCS) ? ~b_crc[{b_idx[1:0], 3'b000} +: 8] : cpu_in.data;
	// see RQ13 RQ17 RQ18; learn_en holds learn select until resolved
	assign b_parsed   = '{stripped: 1'b1,
		map_valid:   b_buf[1][CTG_F_MAPV],
		map:         {b_buf[2][2:0], b_buf[3], b_buf[4], b_buf[5]},
		queue_valid: b_buf[1][CTG_F_QV],
		queue_hi:    b_buf[1][CTG_F_QS],
		learn_en:    b_buf[1][CTG_F_LS],
		tag:         {b_buf[6], cpu_in.data}};

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			b_state       <= B_DATA;
			b_cnt         <= 4'h0;
			b_idx         <= 3'h0;
			b_end         <= 3'h0;
			b_eof         <= 1'b0;
			b_crc         <= CTG_CRC_INIT;
			b_pend        <= '0;
			b_lv          <= 1'b0;
			strip_cnt     <= CTG_CNT_RST;
			cpu_ready_out <= 1'b1;
			fab_valid_out <= 1'b0;
			fab_out       <= '0;
			cmd_valid_out <= 1'b0;
			cmd_out       <= '0;
		end else if (ce_in) begin
			fab_valid_out <= b_emit;
			fab_out.data  <= b_byte;
			fab_out.last  <= b_fcs_end;
			cmd_valid_out <= b_fcs_end;
			if (b_fcs_end) begin
				cmd_out          <= b_pend;
				// see RQ19 RQ20
				cmd_out.learn_en <= b_lv ? b_pend.learn_en :
					~ctrl[CTG_CTRL_LDIS];
			end
			if (b_crc_upd) begin
				b_crc <= ctg_crc_byte(b_crc, b_byte); // see RQ21
			end
			unique case (b_state)
				B_DATA: if (b_take) begin
					b_idx <= 3'h0;
					if (b_cnt <= CTG_SA_END) begin
						b_cnt <= b_cnt + 4'h1;
					end
					if (cpu_in.last) begin
						b_state       <= B_FCS;
						cpu_ready_out <= 1'b0;
					end else if (ctrl[CTG_CTRL_STRIP] && b_cnt == CTG_SA_END) begin
						b_state <= B_HOLD; // see RQ10 RQ11
					end
				end
				B_HOLD: if (b_take) begin
					b_buf[b_idx] <= cpu_in.data;
					b_idx        <= b_idx + 3'h1;
					if (cpu_in.last) begin
						// frame too short for a tag: give back what was held
						b_state       <= B_REPLAY;
						cpu_ready_out <= 1'b0;
						b_end         <= b_idx;
						b_eof         <= 1'b1;
						b_idx         <= 3'h0;
					end else if (b_match) begin
						b_state   <= B_DATA; // see RQ10
						b_pend    <= b_parsed;
						b_lv      <= b_buf[1][CTG_F_LV];
						strip_cnt <= strip_cnt + 16'h0001;
					end else if (b_cmd_done) begin
						b_state       <= B_REPLAY; // see RQ12
						cpu_ready_out <= 1'b0;
						b_end         <= CTG_CMD_LAST;
						b_eof         <= 1'b0;
						b_idx         <= 3'h0;
					end
				end
				B_REPLAY: begin
					b_idx <= b_idx + 3'h1;
					if (b_idx == b_end) begin
						b_idx <= 3'h0;
						if (b_eof) begin
							b_state <= B_FCS;
						end else begin
							b_state       <= B_DATA;
							cpu_ready_out <= 1'b1;
						end
					end
				end
				B_FCS: begin
					b_idx <= b_idx + 3'h1;
					if (b_fcs_end) begin
						b_state       <= B_DATA;
						cpu_ready_out <= 1'b1;
						b_cnt         <= 4'h0;
						b_crc         <= CTG_CRC_INIT;
						b_pend        <= '0;
						b_lv          <= 1'b0;
					end
				end
			endcase
		end
	end

	AST_STRIP_OK: assert property ( // see RQ10 RQ12
		b_match && ce_in |=> b_state == B_DATA && cpu_ready_out &&
		!fab_valid_out)
		else $error("matched command tag not removed");
	AST_MISMATCH: assert property ( // see RQ12
		b_cmd_done && b_buf[0] != label |=> b_state == B_REPLAY &&
		!cpu_ready_out ##1 fab_valid_out && fab_out.data == $past(b_buf[0]))
		else $error("mismatched tag not passed on");
	AST_NORMAL_CMD: assert property ( // see RQ13 RQ17
		cmd_valid_out && !cmd_out.stripped |->
		!cmd_out.map_valid && !cmd_out.queue_valid &&
		cmd_out.learn_en == !ctrl[CTG_CTRL_LDIS])
		else $error("untagged frame got override fields");
	CV_STRIP: cover property (b_match);
	CV_REPLAY: cover property (b_cmd_done && b_buf[0] != label);

endmodule : ctg_cpu_port

// File: hw/ctg_pkg.sv
/*
 * Shared constants, carrier types, state enums and the FCS helper for the
 * management-port trap and special-tag block.
 * Assumes byte-wide frame streams without FCS at the inputs and a single
 * 100 MHz core clock.
 */
package ctg_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the AHB-Lite slave
	localparam logic [7:0]  CTG_ADDR_CTRL  = 8'h00;
	localparam logic [7:0]  CTG_ADDR_LABEL = 8'h04;
	localparam logic [7:0]  CTG_ADDR_VTAG  = 8'h08;
	localparam logic [7:0]  CTG_ADDR_STAT  = 8'h0c;
	localparam int          CTG_CTRL_INS   = 0;
	localparam int          CTG_CTRL_STRIP = 1;
	localparam int          CTG_CTRL_LDIS  = 2;
	localparam int          CTG_CTRL_TAGD  = 3;
	localparam logic [3:0]  CTG_CTRL_RST   = 4'h0;
	localparam logic [7:0]  CTG_LABEL_RST  = 8'h00;
	localparam logic [15:0] CTG_VTAG_RST   = 16'h0000;
	localparam logic [15:0] CTG_CNT_RST    = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// frame layout and trap patterns
	localparam logic [3:0]  CTG_SA_END     = 4'hb;
	localparam logic [4:0]  CTG_ETH_HI_IDX = 5'h0c;
	localparam logic [4:0]  CTG_ETH_LO_IDX = 5'h0d;
	localparam logic [4:0]  CTG_PROTO_IDX  = 5'h17;
	localparam logic [4:0]  CTG_DA_BYTES   = 5'h06;
	localparam logic [39:0] CTG_RSV_PFX    = 40'h0180c20000;
	localparam logic [7:0]  CTG_RSV_LO_MAX = 8'h0f;
	localparam logic [7:0]  CTG_GARP_MIN   = 8'h20;
	localparam logic [7:0]  CTG_GARP_MAX   = 8'h22;
	localparam logic [23:0] CTG_IPMC_PFX   = 24'h01005e;
	localparam logic [15:0] CTG_ETYPE_IP   = 16'h0800;
	localparam logic [7:0]  CTG_PROTO_IGMP = 8'h02;
	localparam logic [1:0]  CTG_INS_LAST   = 2'h3;
	localparam logic [2:0]  CTG_CMD_LAST   = 3'h7;
	localparam logic [2:0]  CTG_FCS_LAST   = 3'h3;
	// command tag flag positions in its second byte
	localparam int          CTG_F_MAPV     = 7;
	localparam int          CTG_F_QV       = 6;
	localparam int          CTG_F_QS       = 5;
	localparam int          CTG_F_LV       = 4;
	localparam int          CTG_F_LS       = 3;
	localparam int          CTG_MAP_W      = 27;
	localparam logic [31:0] CTG_CRC_POLY   = 32'hedb88320;
	localparam logic [31:0] CTG_CRC_INIT   = 32'hffffffff;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} ctg_byte_t;

	typedef struct packed {
		logic                 stripped;
		logic                 map_valid;
		logic [CTG_MAP_W-1:0] map;
		logic                 queue_valid;
		logic                 queue_hi;
		logic                 learn_en;
		logic [15:0]          tag;
	} ctg_cmd_t;

	typedef enum logic [1:0] {A_DATA, A_TAG, A_FCS} ctg_ins_st_t;
	typedef enum logic [1:0] {B_DATA, B_HOLD, B_REPLAY, B_FCS} ctg_rem_st_t;

	// reflected ethernet crc, one byte per call
	function automatic logic [31:0] ctg_crc_byte(input logic [31:0] crc,
			input logic [7:0] data);
		logic [31:0] c;
		c = crc ^ {24'h000000, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CTG_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : ctg_crc_byte

endpackage : ctg_pkg

// File: tb/ctg_mgmt_model.sv
/*
 * Management processor model on the far side of the management port.
 * Assumes the design's byte handshake; sends frames and collects received bytes.
 */
`timescale 1ns/1ps
module ctg_mgmt_model
	import ctg_pkg::*;
(
	input  wire logic               mclk_in,
	input  wire logic               cpu_ready_in,
	input  wire logic               rx_valid_in,
	input  wire ctg_pkg::ctg_byte_t rx_in,
	output logic                    cpu_valid_out,
	output ctg_pkg::ctg_byte_t      cpu_out
);
	import ctg_pkg::*;
	ctg_byte_t rx_q[$];
	initial begin
		cpu_valid_out = 1'b0;
		cpu_out       = '0;
	end
	always @(posedge mclk_in) begin
		if (rx_valid_in === 1'b1) begin
			rx_q.push_back(rx_in);
		end
	end
	////////////////////////////////////////////////////////////////////////
	// flags are {map, queue, queue sel, learn, learn sel} valid bits
	function automatic logic [63:0] cmd_tag(input logic [7:0] lbl,
			input logic [4:0] flg, input logic [26:0] map,
			input logic [15:0] tag);
		return {lbl, flg, 3'h0, 5'h0, map, tag};
	endfunction : cmd_tag
	// released data lines show the inverse so stale bytes never match
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			cpu_valid_out <= 1'b1;
			cpu_out       <= '{data: b[i], last: 1'(i == b.size() - 1)};
			do @(posedge mclk_in); while (cpu_ready_in !== 1'b1);
		end
		cpu_valid_out <= 1'b0;
		cpu_out       <= '{data: ~b[b.size() - 1], last: 1'b0};
	endtask : send
endmodule : ctg_mgmt_model

// File: tb/testbench.sv
/*
 * Self-checking bench: AHB-Lite register access, trap decisions, tag
 * insertion toward the processor and command tag removal toward the fabric.
 * Assumes the hand-over timing: zero-wait bus, registered stream outputs.
 */
`timescale 1ns/1ps
module testbench;
	import ctg_pkg::*;
	typedef logic [7:0] ctg_tbq_t[$];
	logic        mclk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1;
	logic        hsel = 1'b0, hwrite = 1'b0, hresp, hreadyout;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        rx_valid = 1'b0, tx_valid = 1'b0, trap_valid, trap_cpu;
	logic        tx_ready, cpu_valid, pm_valid, cpu_ready, fab_valid;
	logic        cmd_valid;
	logic [4:0]  tx_src = 5'h0;
	ctg_byte_t   rx = '0, tx = '0, cpu, pm, fab;
	ctg_cmd_t    cmd, cmd_seen;
	ctg_byte_t   fab_q[$];
	int          n_mismatch = 0, comparisons = 0, cycles = 0;
	ctg_tbq_t    f, e, hdr, pay;
	always #5 mclk_in = ~mclk_in;

	ctg_cpu_port i_ctg_cpu_port (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.ce_in(ce_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hreadyout), .hrdata_out(hrdata),
		.hreadyout_out(hreadyout), .hresp_out(hresp),
		.rx_valid_in(rx_valid), .rx_in(rx), .trap_valid_out(trap_valid),
		.trap_cpu_out(trap_cpu), .tx_valid_in(tx_valid), .tx_in(tx),
		.tx_src_in(tx_src), .tx_ready_out(tx_ready),
		.cpu_valid_out(cpu_valid), .cpu_out(cpu), .cpu_valid_in(pm_valid),
		.cpu_in(pm), .cpu_ready_out(cpu_ready), .fab_valid_out(fab_valid),
		.fab_out(fab), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
	ctg_mgmt_model i_ctg_mgmt_model (.mclk_in(mclk_in),
		.cpu_ready_in(cpu_ready), .rx_valid_in(cpu_valid), .rx_in(cpu),
		.cpu_valid_out(pm_valid), .cpu_out(pm));

	always @(posedge mclk_in) begin
		if (fab_valid === 1'b1) fab_q.push_back(fab);
		if (cmd_valid === 1'b1) cmd_seen <= cmd;
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic check(string nm, logic [63:0] s, logic [63:0] x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask : check
	task automatic ahb(logic [7:0] a, logic w, logic [31:0] d,
			output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk_in); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk_in); while (hreadyout !== 1'b1);
		r = hrdata;
		check("hresp", 64'(hresp), 64'h0);
	endtask : ahb
	task automatic rd(logic [7:0] a, logic [31:0] x, string nm);
		logic [31:0] r;
		ahb(a, 1'b0, 32'h0, r);
		check(nm, 64'(r), 64'(x));
	endtask : rd
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] r;
		ahb(a, 1'b1, d, r);
	endtask : wr
	// no ready on the receive stream: one byte per cycle
	task automatic send_rx(ctg_tbq_t b);
		foreach (b[i]) begin
			rx_valid <= 1'b1;
			rx       <= '{data: b[i], last: 1'(i == b.size() - 1)};
			@(posedge mclk_in);
		end
		rx_valid <= 1'b0;
		rx       <= '{data: ~b[b.size() - 1], last: 1'b0};
	endtask : send_rx
	task automatic send_tx(ctg_tbq_t b, logic [4:0] src);
		tx_src <= src;
		foreach (b[i]) begin
			tx_valid <= 1'b1;
			tx       <= '{data: b[i], last: 1'(i == b.size() - 1)};
			do @(posedge mclk_in); while (tx_ready !== 1'b1);
		end
		tx_valid <= 1'b0;
		tx       <= '{data: ~b[b.size() - 1], last: 1'b0};
		tx_src   <= ~src;
	endtask : send_tx
	task automatic wait_last(ref ctg_byte_t q[$]);
		int n;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (!(q.size() > 0 && q[$].last === 1'b1) && n < 200);
		@(posedge mclk_in);
	endtask : wait_last
	function automatic logic [31:0] fcs(ctg_tbq_t b);
		logic [31:0] c;
		c = 32'hffffffff;
		foreach (b[i]) for (int k = 0; k < 8; k++)
			c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? 32'hedb88320 : 32'h0);
		return ~c;
	endfunction : fcs
	task automatic check_frame(string nm, ref ctg_byte_t q[$], ctg_tbq_t x);
		logic [31:0] c;
		c = fcs(x);
		for (int i = 0; i < 4; i++) x.push_back(c[8*i+:8]);
		check(nm, 64'(q.size()), 64'(x.size()));
		foreach (x[i]) if (i < q.size())
			check(nm, {q[i].data, q[i].last},
				{x[i], 1'(i == x.size() - 1)});
		q.delete();
	endtask : check_frame
	function automatic ctg_tbq_t mk_rx(logic [47:0] da, logic [7:0] pr);
		ctg_tbq_t b;
		for (int i = 0; i < 24; i++) b.push_back(8'h0);
		for (int i = 0; i < 6; i++) b[i] = da[8*(5-i)+:8];
		for (int i = 6; i < 12; i++) b[i] = 8'h10 + 8'(i);
		b[12] = 8'h08;
		b[23] = pr;
		return b;
	endfunction : mk_rx
	task automatic strip_case(logic [7:0] lbl, logic [4:0] flg,
			logic [47:0] mask, logic [47:0] x, logic match);
		logic [63:0] t;
		t = i_ctg_mgmt_model.cmd_tag(lbl, flg, 27'h6, 16'h1234);
		f = hdr;
		for (int k = 7; k >= 0; k--) f.push_back(t[8*k+:8]);
		f = {f, pay};
		e = match ? {hdr, pay} : f;
		i_ctg_mgmt_model.send(f);
		wait_last(fab_q);
		check_frame("fab", fab_q, e);
		check("cmd", 64'(cmd_seen & mask), 64'(x));
	endtask : strip_case
	////////////////////////////////////////////////////////////////////////
	logic [7:0] sfx[12] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h0f, 8'h20,
		8'h21, 8'h22, 8'h10, 8'h1f, 8'h23, 8'h01};
	initial begin
		repeat (4) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		@(posedge mclk_in);
		rd(CTG_ADDR_CTRL, 32'h0, "ctrl");
		rd(CTG_ADDR_LABEL, 32'h0, "label");
		rd(CTG_ADDR_VTAG, 32'h0, "vtag");
		wr(8'h10, 32'hffffffff);
		rd(8'h10, 32'h0, "unmapped");
		wr(CTG_ADDR_STAT, 32'hffffffff);
		rd(CTG_ADDR_STAT, 32'h0, "stat");
		wr(CTG_ADDR_LABEL, 32'h5a);
		wr(CTG_ADDR_VTAG, 32'h8123);
		rd(CTG_ADDR_LABEL, 32'h5a, "label");
		rd(CTG_ADDR_VTAG, 32'h8123, "vtag");
		// the first eight suffixes trap; 01 and the neighbours 10, 1f, 23 do not
		foreach (sfx[i]) begin
			send_rx(mk_rx({40'h0180c20000, sfx[i]}, 8'h00));
			repeat (2) @(posedge mclk_in);
			check("trap", {trap_valid, trap_cpu}, {1'b1, 1'(i < 8)});
		end
		for (int p = 0; p < 2; p++) begin
			send_rx(mk_rx(48'h01005e000001, p ? 8'h11 : 8'h02));
			@(posedge mclk_in);
			// a low enable must freeze the one-cycle decision pulse
			ce_in <= 1'(p);
			repeat (p ? 1 : 3) @(posedge mclk_in);
			ce_in <= 1'b1;
			check("igmp", {trap_valid, trap_cpu}, {1'b1, 1'(p == 0)});
		end
		for (int m = 0; m < 2; m++) begin
			wr(CTG_ADDR_CTRL, m ? 32'h9 : 32'h0);
			f = {};
			for (int i = 0; i < 16; i++) f.push_back(8'h40 + 8'(i));
			send_tx(f, 5'h13);
			e = f[0:11];
			if (m) e = {e, 8'h81, 8'h23, 8'h5a, 8'h13};
			e = {e, f[12:15]};
			wait_last(i_ctg_mgmt_model.rx_q);
			check_frame("cpu", i_ctg_mgmt_model.rx_q, e);
		end
		wr(CTG_ADDR_CTRL, 32'h6);
		for (int i = 0; i < 12; i++) hdr.push_back(8'h60 + 8'(i));
		for (int i = 0; i < 8; i++) pay.push_back(8'ha0 + 8'(i));
		strip_case(8'h5a, 5'b11110, '1,
			{1'b1, 1'b1, 27'h6, 1'b1, 1'b1, 1'b0, 16'h1234}, 1'b1);
		strip_case(8'h5b, 5'b11110, 48'h800000000000, 48'h0, 1'b0);
		strip_case(8'h5a, 5'b00000, 48'hc00000050000, 48'h800000000000,
			1'b1);
		strip_case(8'h5a, 5'b01011, 48'h000000070000, 48'h000000050000,
			1'b1);
		rd(CTG_ADDR_STAT, 32'h00030009, "stat");
		stop_test();
	end
endmodule : testbench
